// *** verilog/swd_pkg.sv ***
// constants shared by the sanity watchdog: register map, fields, reset values and counts
// assumes a 100 MHz system clock and a word-addressed Avalon-MM register port
//
// Summary of operation
// - watchdog enabled and counting after every reset
// - writing 0x55 then 0xAA restarts timeout
// - reset cause register stays read-only on writes
// - missed service before overflow forces system reset
// - any other value written forces immediate reset
// - clock select 0 picks 1 kHz, 1 bus
// - timeout select zero disables the watchdog
// - 1 kHz overflow after 2^5, 2^8, 2^10
// - bus clock overflow after 2^13, 2^16, 2^18
// - reset defaults: 1 kHz source, longest timeout
// - windowed bus mode: service only in last quarter
// - premature windowed service write resets system immediately
// - window enable ignored with 1 kHz source
// - first write to each option word after reset locks that word
// - bus source: counter holds in stop, debug
// - 1 kHz source: counter zeroed in stop, debug
// - watchdog reset sets its own cause bit
`default_nettype none
package swd_pkg;
   // register word indices on the Avalon address port
   localparam logic [3:0] ADDR_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_OPT_FIRST = 4'h1;
   localparam logic [3:0] ADDR_OPT_SECOND = 4'h2;
   localparam logic [3:0] ADDR_COUNT = 4'h3;
   // service values
   localparam logic [7:0] SERVICE_FIRST = 8'h55;
   localparam logic [7:0] SERVICE_SECOND = 8'hAA;
   // field positions
   localparam int TIMEOUT_LSB = 0;
   localparam int CLKSEL_BIT = 0;
   localparam int WINDOW_BIT = 1;
   localparam int CAUSE_POR_BIT = 7;
   localparam int CAUSE_PIN_BIT = 6;
   localparam int CAUSE_WDG_BIT = 5;
   // reset values
   localparam logic [1:0] TIMEOUT_RST = 2'h3;
   localparam logic CLKSEL_RST = 1'b0;
   localparam logic WINDOW_RST = 1'b0;
   localparam logic [7:0] CAUSE_POR_VALUE = 8'h80;
   // counter width and terminal counts (overflow count minus one)
   localparam int COUNT_WIDTH = 18;
   localparam logic [17:0] LPO_TERM_SHORT = 18'h0001F;
   localparam logic [17:0] LPO_TERM_MID = 18'h000FF;
   localparam logic [17:0] LPO_TERM_LONG = 18'h003FF;
   localparam logic [17:0] BUS_TERM_SHORT = 18'h01FFF;
   localparam logic [17:0] BUS_TERM_MID = 18'h0FFFF;
   localparam logic [17:0] BUS_TERM_LONG = 18'h3FFFF;
   // least elapsed counts before a windowed service is legal
   localparam logic [17:0] BUS_WIN_SHORT = 18'h01800;
   localparam logic [17:0] BUS_WIN_MID = 18'h0C000;
   localparam logic [17:0] BUS_WIN_LONG = 18'h30000;
   // service sequence states
   typedef enum logic [0:0] {
      SEQ_IDLE = 1'b0,
      SEQ_ARMED = 1'b1
   } swd_seq_type;
endpackage
`default_nettype wire

// *** verilog/swd_lpo_sync.sv ***
// synchroniser and rising-edge detector for the free 1 kHz low-power clock
// assumes the low-power clock is far slower than clk and asynchronous to it
`timescale 1ns/1ps
`default_nettype none
module swd_lpo_sync (
   input wire logic clk,
   input wire logic resetn,
   input wire logic lpo_clock,
   output logic lpo_tick
);
   logic meta;
   logic stable;
   logic last;

   // two flops before any logic, third only for the edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta <= 1'b0;
         stable <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= lpo_clock;
         stable <= meta;
         last <= stable;
      end
   end

   // one clk pulse per low-power period
   assign lpo_tick = stable & ~last;
endmodule
`default_nettype wire

// *** verilog/swd_counter.sv ***
// watchdog up-counter with terminal and window compare
// assumes terminal and window_min are steady between clears
`timescale 1ns/1ps
`default_nettype none
module swd_counter #(
   parameter int WIDTH = 18
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic advance,
   input wire logic [WIDTH-1:0] terminal,
   input wire logic [WIDTH-1:0] window_min,
   output logic [WIDTH-1:0] count,
   output logic expired,
   output logic window_open
);
   // overflow is the advance that would pass the terminal count
   assign expired = advance & (count == terminal);
   assign window_open = (count >= window_min);

   // clear wins over advance so service and reset always restart from zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (clear || expired) begin
         count <= '0;
      end else if (advance) begin
         count <= count + 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** verilog/swd_top.sv ***
// sanity watchdog: option registers, service decode, reset request and Avalon-MM slave
// assumes system_reset is a one-cycle-or-longer pulse on clk from the reset controller,
// stop_mode and debug_mode come from clk-domain logic, lpo_clock is an asynchronous pin
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module swd_top (
   input wire logic clk,
   input wire logic resetn,
   input wire logic system_reset,
   input wire logic lpo_clock,
   input wire logic stop_mode,
   input wire logic debug_mode,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic watchdog_reset_req
);
   logic lpo_tick;
   logic [1:0] timeout_select;
   logic watchdog_clock_select;
   logic window_mode_enable;
   logic first_locked;
   logic second_locked;
   logic [7:0] reset_cause_register;
   logic reset_pending;
   swd_pkg::swd_seq_type seq;
   logic [17:0] terminal;
   logic [17:0] window_min;
   logic [17:0] count;
   logic expired;
   logic window_open;
   logic wr_accept;
   logic wr_cause;
   logic is_first;
   logic is_second;
   logic bad_value;
   logic enabled;
   logic windowed;
   logic premature;
   logic service_done;
   logic cfg_init;
   logic frozen;
   logic advance;
   logic clear_cnt;
   logic fire;
   logic [31:0] next_readdata;
   logic [7:0] next_cause;

   swd_lpo_sync u_sync (
      .clk(clk),
      .resetn(resetn),
      .lpo_clock(lpo_clock),
      .lpo_tick(lpo_tick)
   );

   swd_counter #(.WIDTH(swd_pkg::COUNT_WIDTH)) u_count (
      .clk(clk),
      .resetn(resetn),
      .clear(clear_cnt),
      .advance(advance),
      .terminal(terminal),
      .window_min(window_min),
      .count(count),
      .expired(expired),
      .window_open(window_open)
   );

   // a write is taken at the edge where waitrequest is seen low
   assign wr_accept = avs_write & ~avs_waitrequest;
   assign wr_cause = wr_accept & (avs_address == swd_pkg::ADDR_CAUSE);
   assign is_first = (avs_writedata[7:0] == swd_pkg::SERVICE_FIRST);
   assign is_second = (avs_writedata[7:0] == swd_pkg::SERVICE_SECOND);
   assign bad_value = wr_cause & ~is_first & ~is_second;
   assign enabled = (timeout_select != 2'h0);
   // window only exists on the bus clock source
   assign windowed = enabled & watchdog_clock_select & window_mode_enable;
   assign premature = wr_cause & (is_first | is_second) & windowed & ~window_open;
   // only an armed second value counts as service
   assign service_done = wr_cause & is_second & (seq == swd_pkg::SEQ_ARMED) & ~premature;
   assign cfg_init = wr_accept & (((avs_address == swd_pkg::ADDR_OPT_FIRST) & ~first_locked) |
                                  ((avs_address == swd_pkg::ADDR_OPT_SECOND) & ~second_locked));
   assign frozen = stop_mode | debug_mode;
   // bus source counts every clk; low-power source counts synchronised ticks
   assign advance = enabled & ~frozen & (watchdog_clock_select | lpo_tick);
   // low-power source restarts from zero after stop or debug
   assign clear_cnt = system_reset | cfg_init | service_done | ~enabled |
                      (~watchdog_clock_select & frozen);
   assign fire = expired | bad_value | premature;

   // terminal and window pick by source and timeout
   always_comb begin
      terminal = swd_pkg::LPO_TERM_LONG;
      window_min = '0;
      if (watchdog_clock_select) begin
         case (timeout_select)
            2'h1: begin
               terminal = swd_pkg::BUS_TERM_SHORT;
               window_min = swd_pkg::BUS_WIN_SHORT;
            end
            2'h2: begin
               terminal = swd_pkg::BUS_TERM_MID;
               window_min = swd_pkg::BUS_WIN_MID;
            end
            default: begin
               terminal = swd_pkg::BUS_TERM_LONG;
               window_min = swd_pkg::BUS_WIN_LONG;
            end
         endcase
      end else begin
         case (timeout_select)
            2'h1: terminal = swd_pkg::LPO_TERM_SHORT;
            2'h2: terminal = swd_pkg::LPO_TERM_MID;
            default: terminal = swd_pkg::LPO_TERM_LONG;
         endcase
      end
   end

   // write-once options; defaults come back on every system reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timeout_select <= swd_pkg::TIMEOUT_RST;
         watchdog_clock_select <= swd_pkg::CLKSEL_RST;
         window_mode_enable <= swd_pkg::WINDOW_RST;
         first_locked <= 1'b0;
         second_locked <= 1'b0;
      end else if (system_reset) begin
         timeout_select <= swd_pkg::TIMEOUT_RST;
         watchdog_clock_select <= swd_pkg::CLKSEL_RST;
         window_mode_enable <= swd_pkg::WINDOW_RST;
         first_locked <= 1'b0;
         second_locked <= 1'b0;
      end else if (wr_accept) begin
         if ((avs_address == swd_pkg::ADDR_OPT_FIRST) && !first_locked) begin
            timeout_select <= avs_writedata[swd_pkg::TIMEOUT_LSB +: 2];
            first_locked <= 1'b1;
         end
         if ((avs_address == swd_pkg::ADDR_OPT_SECOND) && !second_locked) begin
            watchdog_clock_select <= avs_writedata[swd_pkg::CLKSEL_BIT];
            window_mode_enable <= avs_writedata[swd_pkg::WINDOW_BIT];
            second_locked <= 1'b1;
         end
      end
   end

   // service sequence: first value arms, anything else disarms
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seq <= swd_pkg::SEQ_IDLE;
      end else if (system_reset) begin
         seq <= swd_pkg::SEQ_IDLE;
      end else if (wr_cause) begin
         if (is_first) begin
            seq <= swd_pkg::SEQ_ARMED;
         end else begin
            seq <= swd_pkg::SEQ_IDLE;
         end
      end
   end

   // reset request is a single-cycle pulse per event
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         watchdog_reset_req <= 1'b0;
      end else begin
         watchdog_reset_req <= fire;
      end
   end

   // remembers that the coming system reset is ours; a new event wins over the clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reset_pending <= 1'b0;
      end else if (fire) begin
         reset_pending <= 1'b1;
      end else if (system_reset) begin
         reset_pending <= 1'b0;
      end
   end

   // cause bits reload only on a reset, never on a bus write
   always_comb begin
      next_cause = '0;
      next_cause[swd_pkg::CAUSE_WDG_BIT] = reset_pending | fire;
      next_cause[swd_pkg::CAUSE_PIN_BIT] = ~(reset_pending | fire);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reset_cause_register <= swd_pkg::CAUSE_POR_VALUE;
      end else if (system_reset) begin
         reset_cause_register <= next_cause;
      end
   end

   // read mux; unmapped words read as zero
   always_comb begin
      next_readdata = '0;
      case (avs_address)
         swd_pkg::ADDR_CAUSE: next_readdata[7:0] = reset_cause_register;
         swd_pkg::ADDR_OPT_FIRST: next_readdata[swd_pkg::TIMEOUT_LSB +: 2] = timeout_select;
         swd_pkg::ADDR_OPT_SECOND: begin
            next_readdata[swd_pkg::CLKSEL_BIT] = watchdog_clock_select;
            next_readdata[swd_pkg::WINDOW_BIT] = window_mode_enable;
         end
         swd_pkg::ADDR_COUNT: next_readdata[17:0] = count;
         default: next_readdata = '0;
      endcase
   end

   // one wait state: waitrequest drops for exactly one edge per request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // read data captured while the request waits, so it stands at the taking edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         avs_readdata <= '0;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end
   end

   chk_bad_value_reset: assert property (@(posedge clk) disable iff (!resetn)
      bad_value |=> watchdog_reset_req)
      else $error("wrong service value did not request reset");

   chk_req_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
      (watchdog_reset_req && !$past(fire, 2)) |-> ##1 !watchdog_reset_req)
      else $error("reset request longer than one cycle");

   chk_cause_readonly: assert property (@(posedge clk) disable iff (!resetn)
      (wr_cause && !system_reset) |=> (reset_cause_register == $past(reset_cause_register)))
      else $error("write changed reset cause register");

   chk_service_restart: assert property (@(posedge clk) disable iff (!resetn)
      service_done |=> (count == 18'h00000))
      else $error("service pair did not restart counter");

   chk_lone_second: assert property (@(posedge clk) disable iff (!resetn)
      (wr_cause && is_second && seq == swd_pkg::SEQ_IDLE && watchdog_clock_select && enabled && !frozen
       && !system_reset && !expired && !cfg_init) |=> (count == $past(count) + 18'h00001))
      else $error("lone second value restarted counter");

   chk_window_early: assert property (@(posedge clk) disable iff (!resetn)
      (wr_cause && (is_first || is_second) && windowed && count < window_min) |=> watchdog_reset_req)
      else $error("early windowed service did not reset");

   chk_timeout_reset: assert property (@(posedge clk) disable iff (!resetn)
      (advance && count == terminal && !clear_cnt) |=> (watchdog_reset_req && count == 18'h00000))
      else $error("overflow did not request reset");

   chk_option_lock: assert property (@(posedge clk) disable iff (!resetn)
      (first_locked && !system_reset) |=> $stable(timeout_select))
      else $error("locked timeout select changed");

   chk_disabled_quiet: assert property (@(posedge clk) disable iff (!resetn)
      (timeout_select == 2'h0 && !bad_value) |=> (!watchdog_reset_req && count == 18'h00000))
      else $error("disabled watchdog still counting");

   chk_bus_hold: assert property (@(posedge clk) disable iff (!resetn)
      (watchdog_clock_select && frozen && !clear_cnt) |=> $stable(count))
      else $error("bus-clock counter moved in stop or debug");

   chk_lpo_zero: assert property (@(posedge clk) disable iff (!resetn)
      (!watchdog_clock_select && frozen) |=> (count == 18'h00000))
      else $error("low-power counter not zeroed in stop or debug");

   chk_lpo_idle: assert property (@(posedge clk) disable iff (!resetn)
      (!watchdog_clock_select && !lpo_tick && !clear_cnt) |=> $stable(count))
      else $error("low-power counter moved without a tick");

   chk_defaults: assert property (@(posedge clk) disable iff (!resetn)
      system_reset |=> (timeout_select == 2'h3 && !watchdog_clock_select && count == 18'h00000))
      else $error("reset defaults wrong");

   // defaults pick the low-power source, so counting shows on the first tick after the reset
   chk_enabled_after: assert property (@(posedge clk) disable iff (!resetn)
      (system_reset ##1 (!system_reset && !frozen && !cfg_init && lpo_tick)) |=> (count == 18'h00001))
      else $error("watchdog not counting after reset");

   chk_lpo_terms: assert property (@(posedge clk) disable iff (!resetn)
      (!watchdog_clock_select && timeout_select == 2'h1) |-> (terminal == 18'h0001F))
      else $error("wrong short low-power timeout");

   chk_bus_terms: assert property (@(posedge clk) disable iff (!resetn)
      (watchdog_clock_select && timeout_select == 2'h3) |-> (terminal == 18'h3FFFF))
      else $error("wrong long bus timeout");

   chk_window_size: assert property (@(posedge clk) disable iff (!resetn)
      (watchdog_clock_select && timeout_select == 2'h2) |-> (window_min == 18'h0C000))
      else $error("wrong mid window");

   chk_lpo_nowindow: assert property (@(posedge clk) disable iff (!resetn)
      (!watchdog_clock_select && wr_cause && is_first && !expired) |=> !watchdog_reset_req)
      else $error("window applied on low-power source");

   chk_cause_wdg: assert property (@(posedge clk) disable iff (!resetn)
      ((watchdog_reset_req && !system_reset) ##1 !system_reset ##1 system_reset)
      |=> reset_cause_register[swd_pkg::CAUSE_WDG_BIT])
      else $error("watchdog cause bit not set");
endmodule
`default_nettype wire

// *** sim/tb_windowed_watchdog_timer.sv ***
// self-checking testbench for the sanity watchdog top level, driven over its Avalon-MM port
// assumes the low-power clock may be sped up to 8 clk periods so long counts fit the run
`timescale 1ns/1ps
`default_nettype none
module tb_windowed_watchdog_timer;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic system_reset = 1'b0;
   logic lpo_clock = 1'b0;
   logic stop_mode = 1'b0;
   logic debug_mode = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic watchdog_reset_req;
   logic [31:0] rd;
   int n_errors = 0;
   int checked = 0;
   int n_pulses = 0;
   int cycle_no = 0;
   int t0;
   int p;

   swd_top dut_u (.clk(clk), .resetn(resetn), .system_reset(system_reset), .lpo_clock(lpo_clock),
      .stop_mode(stop_mode), .debug_mode(debug_mode), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .watchdog_reset_req(watchdog_reset_req));

   // 100 MHz system clock
   initial begin
      forever #5 clk = ~clk;
   end
   // low-power clock stand-in: 80 ns period, on the clk falling edges so the synchroniser samples half a period later
   initial begin
      forever #40 lpo_clock = ~lpo_clock;
   end
   // cycle stamp and reset request tally
   always @(posedge clk) begin
      cycle_no <= cycle_no + 1;
      if (watchdog_reset_req === 1'b1) begin
         n_pulses <= n_pulses + 1;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one Avalon transfer; an extra edge at the end so strobes never toggle twice in one step
   task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr_en;
      avs_read <= ~wr_en;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         $display("MISMATCH waitrequest expected 0 seen 1");
      end
      @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(what, rd, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic sys_rst();
      system_reset <= 1'b1;
      @(posedge clk);
      system_reset <= 1'b0;
      @(posedge clk);
   endtask

   // second word first, so the first option word write stamps the start of the count
   task automatic cfg(input logic [1:0] second, input logic [1:0] first);
      wr(4'h2, {30'h00000000, second});
      wr(4'h1, {30'h00000000, first});
      t0 = cycle_no;
   endtask

   task automatic service();
      wr(4'h0, 32'h00000055);
      wr(4'h0, 32'h000000AA);
   endtask

   task automatic expect_pulse(input string what, input int lo, input int hi);
      while (watchdog_reset_req !== 1'b1 && cycle_no - t0 < hi + 20) @(posedge clk);
      check(what, 32'(cycle_no - t0 >= lo && cycle_no - t0 <= hi), 32'h00000001);
      @(posedge clk);
      check("request width", {31'h00000000, watchdog_reset_req}, 32'h00000000);
   endtask

   task automatic t_defaults();
      t0 = cycle_no;
      rdc("cause after power-on", 4'h0, 32'h00000080);
      rdc("timeout default", 4'h1, 32'h00000003);
      rdc("clock select default", 4'h2, 32'h00000000);
      wr(4'h0, 32'h00000055);
      rdc("cause read-only", 4'h0, 32'h00000080);
      wr(4'h9, 32'h00000012);
      rdc("unmapped word", 4'h9, 32'h00000000);
      expect_pulse("default overflow", 8180, 8210);
      sys_rst();
      rdc("cause after watchdog", 4'h0, 32'h00000020);
      $display("done: defaults");
   endtask

   task automatic t_bus_timeouts();
      cfg(2'h1, 2'h1);
      // one bus-clock count has passed since the init write was taken
      bus(1'b0, 4'h3, 32'h00000000);
      check("count cleared by init", rd, 32'h00000001);
      check("count small", 32'(rd < 32'h00000020), 32'h00000001);
      wr(4'h1, 32'h00000003);
      rdc("option locked", 4'h1, 32'h00000001);
      expect_pulse("bus short overflow", 8188, 8200);
      sys_rst();
      cfg(2'h1, 2'h2);
      p = n_pulses;
      idle(8300);
      check("bus mid no overflow", n_pulses, p);
      sys_rst();
      rdc("cause other reset", 4'h0, 32'h00000040);
      $display("done: bus timeouts");
   endtask

   task automatic t_lpo_timeouts();
      cfg(2'h0, 2'h1);
      expect_pulse("lpo short overflow", 245, 268);
      sys_rst();
      cfg(2'h0, 2'h2);
      expect_pulse("lpo mid overflow", 2035, 2062);
      sys_rst();
      $display("done: lpo timeouts");
   endtask

   task automatic t_service();
      cfg(2'h1, 2'h1);
      p = n_pulses;
      idle(5000);
      service();
      idle(5000);
      service();
      idle(2000);
      check("serviced no reset", n_pulses, p);
      idle(4500);
      wr(4'h0, 32'h000000AA);
      idle(4500);
      check("lone second value", n_pulses, p + 1);
      sys_rst();
      $display("done: service");
   endtask

   task automatic t_bad_and_disabled();
      cfg(2'h1, 2'h0);
      p = n_pulses;
      idle(8400);
      check("disabled no reset", n_pulses, p);
      rdc("disabled count", 4'h3, 32'h00000000);
      wr(4'h0, 32'h00000012);
      idle(2);
      check("bad value reset", n_pulses, p + 1);
      sys_rst();
      $display("done: bad value");
   endtask

   task automatic t_window();
      cfg(2'h3, 2'h1);
      p = n_pulses;
      idle(3000);
      wr(4'h0, 32'h00000055);
      idle(2);
      check("early windowed write", n_pulses, p + 1);
      sys_rst();
      cfg(2'h3, 2'h1);
      p = n_pulses;
      idle(6300);
      service();
      idle(3000);
      check("late windowed service", n_pulses, p);
      sys_rst();
      cfg(2'h2, 2'h1);
      idle(20);
      service();
      t0 = cycle_no;
      check("window ignored on lpo", n_pulses, p);
      expect_pulse("lpo restart", 245, 268);
      sys_rst();
      $display("done: window");
   endtask

   task automatic t_low_power();
      logic [31:0] held;
      cfg(2'h1, 2'h3);
      idle(100);
      stop_mode <= 1'b1;
      idle(3);
      bus(1'b0, 4'h3, 32'h00000000);
      held = rd;
      idle(50);
      rdc("stop holds count", 4'h3, held);
      stop_mode <= 1'b0;
      debug_mode <= 1'b1;
      idle(50);
      rdc("debug holds count", 4'h3, held);
      debug_mode <= 1'b0;
      idle(20);
      bus(1'b0, 4'h3, 32'h00000000);
      check("count resumes", 32'(rd > held), 32'h00000001);
      sys_rst();
      cfg(2'h0, 2'h3);
      idle(200);
      stop_mode <= 1'b1;
      idle(20);
      rdc("lpo stop zeroes", 4'h3, 32'h00000000);
      stop_mode <= 1'b0;
      debug_mode <= 1'b1;
      idle(20);
      rdc("lpo debug zeroes", 4'h3, 32'h00000000);
      debug_mode <= 1'b0;
      sys_rst();
      $display("done: low power");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // the scenarios need about 70k cycles; the limit leaves a margin before declaring a hang
   initial begin
      #1000000;
      n_errors++;
      $display("MISMATCH run time expected done seen hang");
      tally_and_finish();
   end

   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_defaults();
      t_bus_timeouts();
      t_lpo_timeouts();
      t_service();
      t_bad_and_disabled();
      t_window();
      t_low_power();
      tally_and_finish();
   end
endmodule
`default_nettype wire
